// ===== src/tpc_trace_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: A read-only flag reports that a new expected trace has been loaded.
// R2: Trace window reads return the actual buffer when select is 0, else
//     the expected buffer.
// R3: The trace window occupies addresses 0x0500 to 0x053F inclusive.
// R4: The actual buffer holds the last accepted message, the expected
//     buffer what software wrote.
// R5: A message is accepted after 3 identical receptions in a row, or 5
//     when the threshold bit is set.
// R6: The boundary follows a line feed, or is the byte with its MSB set.
// R7: Length code 00 gives 1 byte, 01 gives 16 bytes, 10 or 11 give 64.
// R8: The 10-bit SPE pointer is readable, bits 9:8 high, 7:0 low.
// R9: An accepted label equal to the defect value forces E1 AIS on all
//     channels while insertion is enabled.
// R10: One writable enable bit gates that insertion; other bits read 0.
// R11: Without a newly accepted message the actual buffer stays unchanged.
module tpc_trace_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  output logic      [7:0]  regRdData,
  input  wire logic        traceValid,
  input  wire logic [7:0]  traceByte,
  input  wire logic [9:0]  pointerValue,
  input  wire logic        labelValid,
  input  wire logic [7:0]  labelByte,
  output logic      [27:0] e1AisForce,
  output logic             irq
);
  function automatic logic inTrace(input logic [15:0] addr);
    inTrace = (addr >= tpc_pkg::TRACE_BASE) && (addr <= tpc_pkg::TRACE_LAST);
  endfunction
  // Control and configuration registers
  logic [4:0]  ctrlReg;
  logic        newExpReg;
  logic        newExpNext;
  logic [7:0]  c2ValueReg;
  logic        c2EnReg;
  logic [2:0]  maskReg;
  logic [2:0]  statusReg;
  logic [2:0]  statusNext;
  logic [9:0]  ptrReg;
  logic [7:0]  c2AccReg;
  logic        c2SeenReg;
  logic        aisReg;
  logic        aisNext;
  // Read path
  logic [7:0]  rdRegDataReg;
  logic        rdTraceReg;
  logic        rdSelExpReg;
  logic        rdPendReg;
  wire  [7:0]  regReadVal;
  wire  [7:0]  ctrlRead;
  wire  [7:0]  actRdData;
  wire  [7:0]  expRdData;
  // Stream stage
  logic        s1ValidReg;
  logic [7:0]  s1ByteReg;
  logic [5:0]  s1IdxReg;
  logic        s1FirstReg;
  logic        s1LastReg;
  logic        msgSameReg;
  logic [2:0]  repeatReg;
  logic [2:0]  repeatNext;
  wire         aValid;
  wire  [5:0]  aIdx;
  wire         aFirst;
  wire         aLast;
  wire  [7:0]  capRdData;
  wire  [5:0]  capRdAddr;
  wire         byteSame;
  wire         msgSameNow;
  wire         msgDone;
  wire  [2:0]  thrCount;
  wire         acceptHit;
  // Copy engine
  tpc_pkg::tpc_copy_state_t cpStateReg;
  tpc_pkg::tpc_copy_state_t cpStateNext;
  logic [5:0]  cpIdxReg;
  logic [5:0]  cpIdxNext;
  logic [6:0]  cpLenReg;
  logic        cpPendReg;
  logic [5:0]  cpWrIdxReg;
  wire         cpIssue;
  wire         cpLastIssue;
  wire         acceptEvt;
  // Decode
  wire         ctrlWr;
  wire         statusWr;
  wire         maskWr;
  wire         c2ValueWr;
  wire         c2CtrlWr;
  wire         expWe;
  wire         fmtChange;
  wire         aisRise;
  wire  [2:0]  evt;
  wire         selExp;
  wire         thrHigh;
  wire         alignMsb;
  wire  [1:0]  lenCode;
  wire  [1:0]  ptrHigh;

  assign selExp   = ctrlReg[tpc_pkg::CTRL_SEL_BIT];
  assign thrHigh  = ctrlReg[tpc_pkg::CTRL_THR_BIT];
  assign alignMsb = ctrlReg[tpc_pkg::CTRL_ALIGN_BIT];
  assign lenCode  = ctrlReg[tpc_pkg::CTRL_LEN_LSB +: 2];
  assign ptrHigh  = ptrReg[9:8];

  assign ctrlWr    = regWrStb && regAddr == tpc_pkg::CTRL_ADDR;
  assign statusWr  = regWrStb && regAddr == tpc_pkg::IRQ_STATUS_ADDR;
  assign maskWr    = regWrStb && regAddr == tpc_pkg::IRQ_MASK_ADDR;
  assign c2ValueWr = regWrStb && regAddr == tpc_pkg::C2_VALUE_ADDR;
  assign c2CtrlWr  = regWrStb && regAddr == tpc_pkg::C2_CTRL_ADDR;
  // Software writes to the window always land in the expected buffer
  assign expWe     = regWrStb && inTrace(regAddr); // [R3] [R4]
  // A format change makes earlier repetitions meaningless
  assign fmtChange = ctrlWr &&
                     regWrData[tpc_pkg::CTRL_ALIGN_BIT:0] !=
                     ctrlReg[tpc_pkg::CTRL_ALIGN_BIT:0];

  // Register readback
  assign ctrlRead = {2'b00, newExpReg, ctrlReg}; // [R1]
  assign regReadVal =
    (regAddr == tpc_pkg::CTRL_ADDR)       ? ctrlRead :
    (regAddr == tpc_pkg::IRQ_STATUS_ADDR) ? {5'h00, statusReg} :
    (regAddr == tpc_pkg::IRQ_MASK_ADDR)   ? {5'h00, maskReg} :
    (regAddr == tpc_pkg::PTR_UPPER_ADDR)  ? {6'h00, ptrHigh} :  // [R8]
    (regAddr == tpc_pkg::PTR_LOWER_ADDR)  ? ptrReg[7:0] :       // [R8]
    (regAddr == tpc_pkg::C2_VALUE_ADDR)   ? c2ValueReg :
    (regAddr == tpc_pkg::C2_CTRL_ADDR)    ? {6'h00, c2EnReg, 1'b0} : // [R10]
    8'h00;

  // Read data stand only in the cycle after the strobe
  assign regRdData = !rdPendReg ? 8'h00 :
                     !rdTraceReg ? rdRegDataReg :
                     rdSelExpReg ? expRdData : actRdData; // [R2]

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPendReg    <= 1'b0;
      rdTraceReg   <= 1'b0;
      rdSelExpReg  <= 1'b0;
      rdRegDataReg <= 8'h00;
    end else begin
      rdPendReg    <= regRdStb;
      rdTraceReg   <= inTrace(regAddr); // [R3]
      rdSelExpReg  <= selExp;
      rdRegDataReg <= regReadVal;
    end
  end

  // Configuration writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlReg    <= tpc_pkg::CTRL_RST;
      c2ValueReg <= tpc_pkg::C2_VALUE_RST;
      c2EnReg    <= tpc_pkg::C2_EN_RST;
      maskReg    <= tpc_pkg::MASK_RST;
    end else begin
      ctrlReg    <= ctrlWr ? regWrData[4:0] : ctrlReg;
      c2ValueReg <= c2ValueWr ? regWrData : c2ValueReg;
      c2EnReg    <= c2CtrlWr ? regWrData[tpc_pkg::C2_EN_BIT] : c2EnReg;
      maskReg    <= maskWr ? regWrData[2:0] : maskReg;
    end
  end

  // New expected flag: a load sets it, an acceptance consumes it
  assign newExpNext = expWe ? 1'b1 : (acceptEvt ? 1'b0 : newExpReg); // [R1]

  // Sticky status, write one to clear, a new event wins
  assign evt[tpc_pkg::EVT_ACCEPT_BIT] = acceptEvt;
  assign evt[tpc_pkg::EVT_EXPECT_BIT] = expWe;
  assign evt[tpc_pkg::EVT_AIS_BIT]    = aisRise;
  assign statusNext = (statusReg & ~(statusWr ? regWrData[2:0] : 3'h0)) | evt;
  assign irq = |(statusReg & maskReg);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      newExpReg <= 1'b0;
      statusReg <= 3'h0;
      ptrReg    <= tpc_pkg::PTR_RST;
    end else begin
      newExpReg <= newExpNext;
      statusReg <= statusNext;
      ptrReg    <= pointerValue; // [R8]
    end
  end

  // Label match drives AIS on every egress channel
  assign aisNext = c2EnReg && c2SeenReg &&
                   c2AccReg == c2ValueReg; // [R9] [R10]
  assign aisRise = aisNext & ~aisReg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      c2AccReg  <= 8'h00;
      c2SeenReg <= 1'b0;
      aisReg    <= 1'b0;
    end else begin
      c2AccReg  <= labelValid ? labelByte : c2AccReg;
      c2SeenReg <= c2SeenReg | labelValid;
      aisReg    <= aisNext;
    end
  end
  genvar ch;
  generate
    for (ch = 0; ch < tpc_pkg::CHANNELS; ch = ch + 1) begin : g_chan
      assign e1AisForce[ch] = aisReg; // [R9]
    end
  endgenerate

  // Incoming trace bytes
  tpc_trace_aligner u_aligner (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .byteValid (traceValid),
    .byteIn    (traceByte),
    .alignMsb  (alignMsb),
    .msgLen    (tpc_pkg::traceLen(lenCode)),
    .curValid  (aValid),
    .curIdx    (aIdx),
    .curFirst  (aFirst),
    .curLast   (aLast)
  );

  // Capture holds the previous reception, read one cycle ahead
  assign capRdAddr = aValid ? aIdx : cpIdxReg;

  tpc_trace_mem u_capture (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wrEn    (s1ValidReg),
    .wrAddr  (s1IdxReg),
    .wrData  (s1ByteReg),
    .rdAddr  (capRdAddr),
    .rdData  (capRdData)
  );

  assign byteSame   = capRdData == s1ByteReg;
  assign msgSameNow = s1FirstReg ? byteSame : (msgSameReg & byteSame);
  assign msgDone    = s1ValidReg & s1LastReg;
  assign thrCount   = thrHigh ? tpc_pkg::ACCEPT_HIGH : tpc_pkg::ACCEPT_LOW;
  assign repeatNext = !(msgSameNow && repeatReg != 3'h0) ? 3'h1 :
                      (repeatReg == tpc_pkg::REPEAT_MAX) ? repeatReg :
                      repeatReg + 3'h1;
  assign acceptHit  = msgDone && repeatNext == thrCount; // [R5]

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1ValidReg <= 1'b0;
      s1ByteReg  <= 8'h00;
      s1IdxReg   <= 6'h00;
      s1FirstReg <= 1'b0;
      s1LastReg  <= 1'b0;
      msgSameReg <= 1'b0;
      repeatReg  <= 3'h0;
    end else begin
      s1ValidReg <= aValid;
      s1ByteReg  <= traceByte;
      s1IdxReg   <= aIdx;
      s1FirstReg <= aFirst;
      s1LastReg  <= aLast;
      msgSameReg <= s1ValidReg ? msgSameNow : msgSameReg;
      repeatReg  <= fmtChange ? 3'h0 : (msgDone ? repeatNext : repeatReg);
    end
  end

  // Copy engine: moves an accepted message into the actual buffer;
  // the stream keeps priority on the capture read port
  assign cpIssue     = cpStateReg == tpc_pkg::CP_COPY && !aValid;
  assign cpLastIssue = cpIssue && {1'b0, cpIdxReg} == cpLenReg - 7'h01;
  assign acceptEvt   = cpPendReg && cpStateReg == tpc_pkg::CP_IDLE;
  assign cpIdxNext   = acceptHit ? 6'h00 :
                       cpIssue ? cpIdxReg + 6'h01 : cpIdxReg;

  always_comb begin
    cpStateNext = cpStateReg;
    case (cpStateReg)
      tpc_pkg::CP_IDLE: begin
        if (acceptHit) begin
          cpStateNext = tpc_pkg::CP_COPY; // [R5]
        end
      end
      tpc_pkg::CP_COPY: begin
        if (cpLastIssue) begin
          cpStateNext = tpc_pkg::CP_IDLE;
        end
      end
      default: begin
        cpStateNext = tpc_pkg::CP_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpStateReg <= tpc_pkg::CP_IDLE;
      cpIdxReg   <= 6'h00;
      cpLenReg   <= tpc_pkg::LEN_ONE;
      cpPendReg  <= 1'b0;
      cpWrIdxReg <= 6'h00;
    end else begin
      cpStateReg <= cpStateNext;
      cpIdxReg   <= cpIdxNext;
      cpLenReg   <= acceptHit ? tpc_pkg::traceLen(lenCode) : cpLenReg; // [R7]
      cpPendReg  <= cpIssue;
      cpWrIdxReg <= cpIssue ? cpIdxReg : cpWrIdxReg;
    end
  end

  // Actual buffer is written only by the copy engine
  tpc_trace_mem u_actual (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wrEn    (cpPendReg),   // [R4] [R11]
    .wrAddr  (cpWrIdxReg),
    .wrData  (capRdData),
    .rdAddr  (regAddr[5:0]),
    .rdData  (actRdData)
  );

  tpc_trace_mem u_expected (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wrEn    (expWe),       // [R4]
    .wrAddr  (regAddr[5:0]),
    .wrData  (regWrData),
    .rdAddr  (regAddr[5:0]),
    .rdData  (expRdData)
  );

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  a_new_ready: assert property (expWe |=> newExpReg) // [R1]
    else $error("expected load did not raise ready flag");
  a_read_select: assert property ( // [R2]
    regRdStb && inTrace(regAddr) && !selExp |=> regRdData == actRdData)
    else $error("select zero did not return actual buffer");
  a_unmapped_zero: assert property ( // [R3]
    regRdStb && regAddr > tpc_pkg::TRACE_LAST |=> regRdData == 8'h00)
    else $error("read above trace window not zero");
  a_accept_count: assert property (acceptHit |-> msgSameNow && // [R5]
    (thrHigh ? repeatReg == 3'h4 : repeatReg == 3'h2))
    else $error("message accepted at wrong repeat count");
  a_ptr_upper: assert property (regRdStb && // [R8]
    regAddr == tpc_pkg::PTR_UPPER_ADDR |=>
    regRdData == {6'h00, $past(ptrHigh)})
    else $error("pointer upper byte wrong");
  a_ais_match: assert property (c2EnReg && c2SeenReg && // [R9]
    c2AccReg == c2ValueReg && $stable(c2AccReg) |=> e1AisForce == {28{1'b1}})
    else $error("AIS not forced on label match");
  a_ais_disable: assert property (!c2EnReg |=> e1AisForce == '0) // [R10]
    else $error("AIS forced while insertion disabled");
  a_keep_actual: assert property (cpPendReg |-> // [R11]
    $past(cpStateReg) == tpc_pkg::CP_COPY)
    else $error("actual buffer written outside a copy");
  c_accept: cover property (acceptEvt);
  c_ais_on: cover property (aisRise);
  c_read_expected: cover property (regRdStb && inTrace(regAddr) && selExp);
endmodule
`default_nettype wire

// ===== src/tpc_pkg.sv
package tpc_pkg;

  // Register map
  localparam logic [15:0] CTRL_ADDR       = 16'h02A3;
  localparam logic [15:0] IRQ_STATUS_ADDR = 16'h02A4;
  localparam logic [15:0] IRQ_MASK_ADDR   = 16'h02A5;
  localparam logic [15:0] PTR_UPPER_ADDR  = 16'h02A6;
  localparam logic [15:0] PTR_LOWER_ADDR  = 16'h02A7;
  localparam logic [15:0] C2_VALUE_ADDR   = 16'h02B9;
  localparam logic [15:0] C2_CTRL_ADDR    = 16'h02BA;
  localparam logic [15:0] TRACE_BASE      = 16'h0500;
  localparam logic [15:0] TRACE_LAST      = 16'h053F;

  // Field positions
  localparam int CTRL_NEW_BIT   = 5;
  localparam int CTRL_SEL_BIT   = 4;
  localparam int CTRL_THR_BIT   = 3;
  localparam int CTRL_ALIGN_BIT = 2;
  localparam int CTRL_LEN_LSB   = 0;
  localparam int C2_EN_BIT      = 1;
  localparam int EVT_ACCEPT_BIT = 0;
  localparam int EVT_EXPECT_BIT = 1;
  localparam int EVT_AIS_BIT    = 2;
  localparam int EVT_W          = 3;
  localparam int CHANNELS       = 28;

  // Reset values
  localparam logic [4:0]  CTRL_RST     = 5'h00;
  localparam logic [7:0]  C2_VALUE_RST = 8'h00;
  localparam logic        C2_EN_RST    = 1'b0;
  localparam logic [2:0]  MASK_RST     = 3'h0;
  localparam logic [9:0]  PTR_RST      = 10'h000;

  // Trace message constants
  localparam logic [7:0] LF_BYTE       = 8'h0A;
  localparam logic [2:0] ACCEPT_LOW    = 3'h3;
  localparam logic [2:0] ACCEPT_HIGH   = 3'h5;
  localparam logic [2:0] REPEAT_MAX    = 3'h7;
  localparam logic [6:0] LEN_ONE       = 7'h01;
  localparam logic [6:0] LEN_SIXTEEN   = 7'h10;
  localparam logic [6:0] LEN_SIXTYFOUR = 7'h40;

  typedef enum logic {CP_IDLE, CP_COPY} tpc_copy_state_t;

  function automatic logic [6:0] traceLen(input logic [1:0] code);
    traceLen = (code == 2'h0) ? LEN_ONE :
               (code == 2'h1) ? LEN_SIXTEEN : LEN_SIXTYFOUR;
  endfunction

endpackage

// ===== src/tpc_trace_mem.sv
`timescale 1ns/1ps
`default_nettype none
module tpc_trace_mem (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       wrEn,
  input  wire logic [5:0] wrAddr,
  input  wire logic [7:0] wrData,
  input  wire logic [5:0] rdAddr,
  output logic      [7:0] rdData
);
  logic [7:0] store [0:63];

  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  // Registered read: data for rdAddr stand one cycle later
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 8'h00;
    end else begin
      rdData <= store[rdAddr];
    end
  end
endmodule
`default_nettype wire

// ===== src/tpc_trace_aligner.sv
`timescale 1ns/1ps
`default_nettype none
module tpc_trace_aligner (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       byteValid,
  input  wire logic [7:0] byteIn,
  input  wire logic       alignMsb,
  input  wire logic [6:0] msgLen,
  output logic            curValid,
  output logic      [5:0] curIdx,
  output logic            curFirst,
  output logic            curLast
);
  logic       lockReg;
  logic       lockNext;
  logic [5:0] idxReg;
  logic [5:0] idxNext;
  logic       prevLfReg;
  wire        singleByte;
  wire        startHit;

  assign singleByte = msgLen == tpc_pkg::LEN_ONE;
  // Boundary: byte after a line feed, or a byte with its MSB set
  assign startHit = singleByte | (alignMsb ? byteIn[7] : prevLfReg); // [R6]
  assign curValid = byteValid & (startHit | lockReg);
  assign curIdx   = startHit ? 6'h00 : idxReg;
  assign curFirst = startHit;
  assign curLast  = {1'b0, curIdx} == msgLen - 7'h01; // [R7]
  assign idxNext  = curValid ? (curIdx + 6'h01) : idxReg;
  // Every message has to begin on a fresh boundary
  assign lockNext = byteValid ? (curValid & ~curLast) : lockReg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockReg   <= 1'b0;
      idxReg    <= 6'h00;
      prevLfReg <= 1'b0;
    end else begin
      lockReg   <= lockNext;
      idxReg    <= idxNext;
      prevLfReg <= byteValid ? (byteIn == tpc_pkg::LF_BYTE) : prevLfReg;
    end
  end

  a_msb_boundary: assert property ( // [R6]
    @(posedge sys_clk) disable iff (!rst_n)
    alignMsb && byteValid && byteIn[7] |-> curValid && curIdx == 6'h00)
    else $error("MSB byte not taken as message start");
  a_single_length: assert property ( // [R7]
    @(posedge sys_clk) disable iff (!rst_n)
    msgLen == 7'h01 && byteValid |-> curValid && curLast)
    else $error("one byte message not closed at once");
endmodule
`default_nettype wire

// ===== sim/tpc_stream_model.sv
`timescale 1ns/1ps
`default_nettype none
module tpc_stream_model (
  input  wire logic       sys_clk,
  output logic            traceValid,
  output logic      [7:0] traceByte,
  output logic      [9:0] pointerValue,
  output logic            labelValid,
  output logic      [7:0] labelByte
);
  initial begin
    traceValid   = 1'b0;
    traceByte    = 8'h00;
    pointerValue = 10'h000;
    labelValid   = 1'b0;
    labelByte    = 8'h00;
  end

  // Pulses sit two cycles apart; the data line turns over between them
  task automatic sendByte(input logic [7:0] b);
    @(posedge sys_clk);
    traceValid <= 1'b1;
    traceByte  <= b;
    @(posedge sys_clk);
    traceValid <= 1'b0;
    traceByte  <= ~b;
  endtask

  task automatic setPointer(input logic [9:0] p);
    pointerValue <= p;
  endtask

  task automatic sendLabel(input logic [7:0] b);
    @(posedge sys_clk);
    labelValid <= 1'b1;
    labelByte  <= b;
    @(posedge sys_clk);
    labelValid <= 1'b0;
    labelByte  <= ~b;
  endtask
endmodule
`default_nettype wire

// ===== sim/tpc_trace_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tpc_trace_ctrl_bench;
  logic        sys_clk, rst_n, regWrStb, regRdStb, havePrev;
  logic [15:0] regAddr;
  logic [7:0]  regWrData, regRdData, prevFirst;
  logic [27:0] e1AisForce;
  logic        irq;
  logic        traceValid, labelValid;
  logic [7:0]  traceByte, labelByte;
  logic [9:0]  pointerValue;
  int          nMismatch, testsRun;

  tpc_stream_model model (
    .sys_clk      (sys_clk),
    .traceValid   (traceValid),
    .traceByte    (traceByte),
    .pointerValue (pointerValue),
    .labelValid   (labelValid),
    .labelByte    (labelByte)
  );

  tpc_trace_ctrl DUT (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .regAddr      (regAddr),
    .regWrData    (regWrData),
    .regWrStb     (regWrStb),
    .regRdStb     (regRdStb),
    .regRdData    (regRdData),
    .traceValid   (traceValid),
    .traceByte    (traceByte),
    .pointerValue (pointerValue),
    .labelValid   (labelValid),
    .labelByte    (labelByte),
    .e1AisForce   (e1AisForce),
    .irq          (irq)
  );

  always #2 sys_clk = ~sys_clk;

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge sys_clk);
    regWrStb  <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdChk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1 check(28'(regRdData), 28'(exp));
  endtask

  function automatic logic [7:0] msgByte(input int len, input logic msb,
                                         input logic [7:0] base, input int i);
    if (msb) msgByte = (i == 0) ? (base | 8'h80) : base + 8'(i);
    else msgByte = (i == len - 1) ? 8'h0A : base + 8'(i);
  endfunction

  task automatic runTrace(input logic [1:0] code, input logic msb,
                          input logic thr, input logic [7:0] base,
                          input int reps);
    int         len;
    logic [7:0] e;
    len = (code == 2'h0) ? 1 : (code == 2'h1) ? 16 : 64;
    wr(tpc_pkg::CTRL_ADDR, {4'h0, thr, msb, code});
    wr(tpc_pkg::IRQ_STATUS_ADDR, 8'h07);
    if (!msb && !havePrev) model.sendByte(8'h0A);
    for (int r = 0; r < reps; r++) begin
      for (int i = 0; i < len; i++) begin
        model.sendByte(msgByte(len, msb, base, i));
      end
      // Leaves room for the copy into the buffer to finish
      repeat (80) @(posedge sys_clk);
      if (r == reps - 2) begin
        rdChk(tpc_pkg::IRQ_STATUS_ADDR, 8'h00);
        if (havePrev) rdChk(tpc_pkg::TRACE_BASE, prevFirst);
      end
    end
    rdChk(tpc_pkg::IRQ_STATUS_ADDR, 8'h01);
    rdChk(tpc_pkg::CTRL_ADDR, {4'h0, thr, msb, code});
    for (int i = 0; i < len; i++) begin
      e = msgByte(len, msb, base, i);
      rdChk(tpc_pkg::TRACE_BASE + 16'(i), e);
    end
    prevFirst = msgByte(len, msb, base, 0);
    havePrev  = 1'b1;
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    nMismatch++;
    conclude();
  end

  initial begin
    sys_clk   = 1'b0;
    rst_n     = 1'b0;
    regWrStb  = 1'b0;
    regRdStb  = 1'b0;
    regAddr   = 16'h0000;
    regWrData = 8'h00;
    havePrev  = 1'b0;
    prevFirst = 8'h00;
    nMismatch = 0;
    testsRun  = 0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 check(e1AisForce, 28'h0000000);
    check(28'(irq), 28'h0);
    rdChk(tpc_pkg::CTRL_ADDR, 8'h00);
    rdChk(tpc_pkg::PTR_UPPER_ADDR, 8'h00);
    rdChk(tpc_pkg::PTR_LOWER_ADDR, 8'h00);
    rdChk(tpc_pkg::C2_VALUE_ADDR, 8'h00);
    rdChk(tpc_pkg::C2_CTRL_ADDR, 8'h00);
    rdChk(tpc_pkg::IRQ_MASK_ADDR, 8'h00);
    rdChk(16'h0123, 8'h00);
    // Read-only pointer bytes ignore writes
    wr(tpc_pkg::PTR_LOWER_ADDR, 8'h77);
    @(posedge sys_clk);
    model.setPointer(10'h2A5);
    rdChk(tpc_pkg::PTR_UPPER_ADDR, 8'h02);
    rdChk(tpc_pkg::PTR_LOWER_ADDR, 8'hA5);
    // Expected buffer at both window edges, read back through select
    wr(tpc_pkg::CTRL_ADDR, 8'h10);
    wr(tpc_pkg::TRACE_BASE, 8'h5A);
    wr(tpc_pkg::TRACE_LAST, 8'hC3);
    rdChk(tpc_pkg::CTRL_ADDR, 8'h30);
    rdChk(tpc_pkg::TRACE_BASE, 8'h5A);
    rdChk(tpc_pkg::TRACE_LAST, 8'hC3);
    rdChk(tpc_pkg::TRACE_LAST + 16'h0001, 8'h00);
    rdChk(tpc_pkg::TRACE_BASE - 16'h0001, 8'h00);
    rdChk(tpc_pkg::IRQ_STATUS_ADDR, 8'h02);
    wr(tpc_pkg::IRQ_MASK_ADDR, 8'h02);
    #1 check(28'(irq), 28'h1);
    wr(tpc_pkg::IRQ_STATUS_ADDR, 8'h02);
    #1 check(28'(irq), 28'h0);
    runTrace(2'h1, 1'b0, 1'b0, 8'h20, 3);
    wr(tpc_pkg::IRQ_MASK_ADDR, 8'h01);
    #1 check(28'(irq), 28'h1);
    runTrace(2'h3, 1'b0, 1'b0, 8'h30, 3);
    runTrace(2'h1, 1'b1, 1'b1, 8'h40, 5);
    runTrace(2'h0, 1'b1, 1'b0, 8'h50, 3);
    runTrace(2'h2, 1'b1, 1'b0, 8'h28, 3);
    // Label match gated by the enable bit
    wr(tpc_pkg::IRQ_STATUS_ADDR, 8'h07);
    wr(tpc_pkg::C2_CTRL_ADDR, 8'hFF);
    rdChk(tpc_pkg::C2_CTRL_ADDR, 8'h02);
    wr(tpc_pkg::C2_CTRL_ADDR, 8'h00);
    wr(tpc_pkg::C2_VALUE_ADDR, 8'h3C);
    rdChk(tpc_pkg::C2_VALUE_ADDR, 8'h3C);
    model.sendLabel(8'h3C);
    repeat (3) @(posedge sys_clk);
    #1 check(e1AisForce, 28'h0000000);
    wr(tpc_pkg::C2_CTRL_ADDR, 8'h02);
    repeat (3) @(posedge sys_clk);
    #1 check(e1AisForce, 28'hFFFFFFF);
    rdChk(tpc_pkg::IRQ_STATUS_ADDR, 8'h04);
    model.sendLabel(8'h3D);
    repeat (3) @(posedge sys_clk);
    #1 check(e1AisForce, 28'h0000000);
    conclude();
  end
endmodule
`default_nettype wire
